// File: inc/dcil_map.vh
`ifndef DCIL_MAP_VH
`define DCIL_MAP_VH

// number of internal interrupt sources and width of their index
`define DCIL_NUM_SRC 4
`define DCIL_IDX_W 2

// status field inside the vector byte
`define DCIL_VEC_ST_LSB 1
`define DCIL_VEC_ST_W 3

// vector read when nothing is pending
`define DCIL_NO_VECTOR 8'hFF

// reset values
`define DCIL_RST_VECTOR 8'h00
`define DCIL_RST_PIN_HI 1'b1
`define DCIL_RST_LATCH 1'b0

// depth of the pin synchronisers
`define DCIL_SYNC_STAGES 2

`endif

// File: logic/dcil_sync2.v
`timescale 1ns/10ps
`include "dcil_map.vh"
module dcil_sync2
#(
  parameter WIDTH = 1
)
(
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // asynchronous levels in, synchronised levels out
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // strobes are active low, so the idle value is all ones
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      meta_r <= {WIDTH{`DCIL_RST_PIN_HI}};
      sync_r <= {WIDTH{`DCIL_RST_PIN_HI}};
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

// File: logic/dcil_src.v
`timescale 1ns/10ps
`include "dcil_map.vh"
module dcil_src
(
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // event and clears
  input wire set_in,
  input wire ack_busy_in,
  input wire clr_in,
  input wire grant_in,
  input wire svc_clr_in,
  // latch state
  output wire pending_out,
  output wire in_service_out
);

  reg pending_latch_r;
  reg held_r;
  reg in_service_latch_r;
  wire set_now;

  // an event during acknowledge is parked and applied once the cycle ends
  assign set_now = (set_in | held_r) & ~ack_busy_in;

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pending_latch_r <= `DCIL_RST_LATCH;
      held_r <= `DCIL_RST_LATCH;
      in_service_latch_r <= `DCIL_RST_LATCH;
    end
    else
    begin
      held_r <= ack_busy_in & (held_r | set_in);
      // set wins over a clear in the same cycle
      if (set_now)
        pending_latch_r <= 1'b1;
      else if (clr_in)
        pending_latch_r <= 1'b0;
      if (grant_in)
        in_service_latch_r <= 1'b1;
      else if (svc_clr_in)
        in_service_latch_r <= 1'b0;
    end
  end

  assign pending_out = pending_latch_r;
  assign in_service_out = in_service_latch_r;

endmodule

// File: logic/dcil_core.v
`timescale 1ns/10ps
`include "dcil_map.vh"
// Contract
// - internal event sets pending latch; pending drives request, any in-service blocks it.
// - pending latch does not set during acknowledge; event held until it ends.
// - pending latch clears by software command or implicit data access.
// - in-service sets on acknowledge only with chain input high and pending.
// - chain input low at acknowledge: no in-service set, no vector driven.
// - in-service clears only by explicit software command, no opcode watch.
// - outside acknowledge chain output follows in-service only.
// - return opcode is never decoded; pending never raises chain output.
// - disable-lower-chain command forces chain output low unconditionally.
// - winning device drives vector while acknowledge and read strobe active.
// - read and write strobes low together reset the device.
// - vector register readable outside acknowledge, showing status even without status mode.
// - request output is open drain, active low, only ever pulled low.
// - master enable clear: no request and acknowledge ignored.
module dcil_core
#(
  parameter NUM_SRC = `DCIL_NUM_SRC,
  parameter IDX_W = `DCIL_IDX_W
)
(
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // processor pins, asynchronous
  input wire ce_n_in,
  input wire rd_n_in,
  input wire wr_n_in,
  input wire vec_sel_in,
  input wire irq_acknowledge_n_in,
  input wire chain_enable_in,
  // data bus, three signals of a two-way pin
  input wire [7:0] data_in,
  output wire [7:0] data_out,
  output wire data_oe_out,
  // interrupt request, open drain
  output wire irq_n_out,
  output wire irq_oe_out,
  // chain towards lower priority devices
  output wire chain_enable_out,
  // internal events and clears from the rest of the device
  input wire [NUM_SRC-1:0] irq_event_in,
  input wire [NUM_SRC-1:0] clear_pending_cmd_in,
  input wire [NUM_SRC-1:0] data_access_in,
  input wire clear_in_service_cmd_in,
  // configuration
  input wire master_irq_enable_in,
  input wire vector_includes_status_in,
  input wire disable_lower_chain_cmd_in,
  input wire [7:0] base_vector_in,
  // status
  output wire [NUM_SRC-1:0] pending_out,
  output wire [NUM_SRC-1:0] in_service_out,
  output wire [7:0] current_vector_out
);

  localparam [IDX_W-1:0] IDX_ZERO = {IDX_W{1'b0}};
  localparam [`DCIL_VEC_ST_W-IDX_W-1:0] ST_PAD =
    {(`DCIL_VEC_ST_W-IDX_W){1'b0}};
  localparam [NUM_SRC-1:0] SRC_ONE = {{(NUM_SRC-1){1'b0}}, 1'b1};

  // synchronised pins and internal reset
  wire [5:0] pins_raw;
  wire [5:0] pins_s;
  wire ce_s;
  wire rd_s;
  wire wr_s;
  wire vsel_s;
  wire ack_s;
  wire chain_s;
  wire strobe_rst;
  wire dev_rst;

  // latch state and priority
  wire [NUM_SRC-1:0] ip;
  wire [NUM_SRC-1:0] in_service_latch;
  wire [NUM_SRC-1:0] grant;
  wire [NUM_SRC-1:0] svc_clr;
  wire [NUM_SRC-1:0] clr_any;
  wire any_ip;
  wire any_ius;
  wire ack_act;
  wire ack_start;
  wire [NUM_SRC-1:0] ip_first;
  wire [NUM_SRC-1:0] ius_first;
  wire [IDX_W-1:0] top_ip_idx;

  // vector paths
  wire [7:0] status_vec;
  wire [7:0] cur_vec;
  wire [7:0] ack_vec;

  // registered state and next values
  reg ack_prev_r;
  reg won_r;
  reg won_nxt;
  reg [IDX_W-1:0] win_idx_r;
  reg [IDX_W-1:0] win_idx_nxt;
  reg chain_out_r;
  reg chain_out_nxt;
  reg irq_r;
  reg [7:0] data_r;
  reg [7:0] data_nxt;
  reg data_oe_r;
  reg data_oe_nxt;
  reg [7:0] cur_vec_r;

  // every processor pin passes two flops before logic reads it
  assign pins_raw = {chain_enable_in, irq_acknowledge_n_in, vec_sel_in,
                     wr_n_in, rd_n_in, ce_n_in};

  // syncs stay on rst_in alone, so a strobe reset can see its own release
  dcil_sync2 #(
    .WIDTH(6)
  ) u_pin_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  assign ce_s = ~pins_s[0];
  assign rd_s = ~pins_s[1];
  assign wr_s = ~pins_s[2];
  assign vsel_s = pins_s[3];
  assign ack_s = ~pins_s[4];
  assign chain_s = pins_s[5];

  // both strobes low at once is the hardware reset request
  assign strobe_rst = rd_s & wr_s;
  assign dev_rst = rst_in | strobe_rst;

  // highest priority is the lowest index
  function [IDX_W-1:0] top_index;
    input [NUM_SRC-1:0] vec;
    integer i;
    begin
      top_index = IDX_ZERO;
      for (i = NUM_SRC - 1; i >= 0; i = i - 1)
        if (vec[i])
          top_index = i[IDX_W-1:0];
    end
  endfunction

  // status field of a vector replaced by a source index
  function [7:0] with_status;
    input [7:0] vec;
    input [IDX_W-1:0] idx;
    begin
      with_status = vec | ({{(8-`DCIL_VEC_ST_W){1'b0}}, ST_PAD, idx} <<
                           `DCIL_VEC_ST_LSB);
    end
  endfunction

  assign any_ip = |ip;
  assign any_ius = |in_service_latch;
  assign top_ip_idx = top_index(ip);
  // the lowest set bit of each latch vector is its top priority source
  assign ip_first = ip & ~(ip - SRC_ONE);
  assign ius_first = in_service_latch & ~(in_service_latch - SRC_ONE);

  // acknowledge counts only while the master enable is set
  assign ack_act = ack_s & master_irq_enable_in;
  assign ack_start = ack_act & ~ack_prev_r;

  // the dedicated acknowledge strobe is the only way a cycle starts
  always @*
  begin
    won_nxt = won_r;
    win_idx_nxt = win_idx_r;
    if (!ack_act)
      won_nxt = 1'b0;
    else if (ack_start)
    begin
      // low chain input means an upstream device owns this cycle
      won_nxt = chain_s & any_ip;
      win_idx_nxt = top_ip_idx;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g = g + 1)
    begin : g_src
      assign grant[g] = ack_start & won_nxt & ip_first[g];
      // only the command clears service, no bus opcode is watched
      assign svc_clr[g] = clear_in_service_cmd_in &
                          ius_first[g];
      assign clr_any[g] = clear_pending_cmd_in[g] |
                          data_access_in[g];

      dcil_src u_src (
        .clk_in(clk_in),
        .rst_in(dev_rst),
        .set_in(irq_event_in[g]),
        // an ignored acknowledge does not hold events off
        .ack_busy_in(ack_act),
        .clr_in(clr_any[g]),
        .grant_in(grant[g]),
        .svc_clr_in(svc_clr[g]),
        .pending_out(ip[g]),
        .in_service_out(in_service_latch[g])
      );
    end
  endgenerate

  // chain output: pending matters only inside the acknowledge cycle
  always @*
  begin
    if (disable_lower_chain_cmd_in)
      chain_out_nxt = 1'b0;
    else if (ack_act)
      chain_out_nxt = chain_s & ~any_ius & ~any_ip;
    else
      chain_out_nxt = chain_s & ~any_ius;
  end

  // status field always reflects the top pending source
  assign status_vec = base_vector_in &
                      ~({{(8-`DCIL_VEC_ST_W){1'b0}},
                         {`DCIL_VEC_ST_W{1'b1}}} << `DCIL_VEC_ST_LSB);
  assign cur_vec = any_ip ? with_status(status_vec, top_ip_idx) :
                   `DCIL_NO_VECTOR;
  // acknowledge vector carries status only in status mode
  assign ack_vec = vector_includes_status_in ?
                   with_status(status_vec, win_idx_r) : base_vector_in;

  // bus read: vector on acknowledge, else register reads when selected
  always @*
  begin
    data_nxt = data_r;
    data_oe_nxt = 1'b0;
    if (ack_act)
    begin
      if (won_r & rd_s)
      begin
        data_nxt = ack_vec;
        data_oe_nxt = 1'b1;
      end
    end
    else if (ce_s & rd_s & ~wr_s)
    begin
      data_oe_nxt = 1'b1;
      if (vsel_s)
        data_nxt = cur_vec;
      else
        data_nxt = {in_service_latch, ip};
    end
  end

  always @(posedge clk_in)
  begin
    if (dev_rst)
    begin
      ack_prev_r <= 1'b0;
      won_r <= 1'b0;
      win_idx_r <= IDX_ZERO;
      chain_out_r <= 1'b0;
      irq_r <= 1'b0;
      data_r <= `DCIL_RST_VECTOR;
      data_oe_r <= 1'b0;
      cur_vec_r <= `DCIL_NO_VECTOR;
    end
    else
    begin
      ack_prev_r <= ack_act;
      won_r <= won_nxt;
      win_idx_r <= win_idx_nxt;
      chain_out_r <= chain_out_nxt;
      // request while enabled, pending and nothing under service
      irq_r <= master_irq_enable_in & any_ip & ~any_ius;
      data_r <= data_nxt;
      data_oe_r <= data_oe_nxt;
      cur_vec_r <= cur_vec;
    end
  end

  // open drain: the pin level is never driven high
  assign irq_n_out = 1'b0;
  assign irq_oe_out = irq_r;

  // outputs straight from the latches and flops
  assign chain_enable_out = chain_out_r;
  assign data_out = data_r;
  assign data_oe_out = data_oe_r;
  assign pending_out = ip;
  assign in_service_out = in_service_latch;
  assign current_vector_out = cur_vec_r;

  // data_in is unused: writes come over the command ports, not the bus
  wire unused_data;
  assign unused_data = ^data_in;

endmodule

// File: bench/dcil_core_checker.sv
`timescale 1ns/10ps
module dcil_core_checker
#(
  parameter NUM_SRC = 4
)
(
  // watched pins
  input wire clk_in,
  input wire rst_in,
  input wire rd_n_in,
  input wire wr_n_in,
  input wire irq_acknowledge_n_in,
  input wire chain_enable_in,
  input wire clear_in_service_cmd_in,
  input wire master_irq_enable_in,
  input wire disable_lower_chain_cmd_in,
  input wire [7:0] base_vector_in,
  input wire data_oe_out,
  input wire irq_n_out,
  input wire irq_oe_out,
  input wire chain_enable_out,
  input wire [NUM_SRC-1:0] pending_out,
  input wire [NUM_SRC-1:0] in_service_out,
  input wire [7:0] current_vector_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  open_drain_a: assert property (irq_n_out == 1'b0)
    else $error("request pin driven high");
  no_enable_a: assert property (!master_irq_enable_in |=> !irq_oe_out)
    else $error("request without master enable");
  lower_chain_a: assert property (disable_lower_chain_cmd_in |=>
    !chain_enable_out) else $error("chain not disabled");
  chain_busy_a: assert property (|in_service_out |=> !chain_enable_out)
    else $error("chain open while in service");
  vec_status_a: assert property (pending_out[0] |=>
    current_vector_out == {$past(base_vector_in[7:4]), 3'h0,
    $past(base_vector_in[0])}) else $error("vector status wrong");
  grant_cause_a: assert property ($rose(|in_service_out) |->
    $past(|pending_out) && $past(master_irq_enable_in) &&
    $past(chain_enable_in, 3) && !$past(irq_acknowledge_n_in, 3))
    else $error("grant without cause");
  service_hold_a: assert property (|in_service_out &&
    !clear_in_service_cmd_in && (rd_n_in || wr_n_in) &&
    $past(rd_n_in || wr_n_in) && $past(rd_n_in || wr_n_in, 2) |=>
    |in_service_out) else $error("in service lost");
  bus_drive_a: assert property (data_oe_out |-> !$past(rd_n_in, 3))
    else $error("bus driven without read");
endmodule
bind dcil_core dcil_core_checker #(.NUM_SRC(NUM_SRC)) chk (
  .clk_in(clk_in), .rst_in(rst_in), .rd_n_in(rd_n_in), .wr_n_in(wr_n_in),
  .irq_acknowledge_n_in(irq_acknowledge_n_in),
  .chain_enable_in(chain_enable_in),
  .clear_in_service_cmd_in(clear_in_service_cmd_in),
  .master_irq_enable_in(master_irq_enable_in),
  .disable_lower_chain_cmd_in(disable_lower_chain_cmd_in),
  .base_vector_in(base_vector_in), .data_oe_out(data_oe_out),
  .irq_n_out(irq_n_out), .irq_oe_out(irq_oe_out),
  .chain_enable_out(chain_enable_out), .pending_out(pending_out),
  .in_service_out(in_service_out), .current_vector_out(current_vector_out));

// File: bench/dcil_cpu_model.sv
`timescale 1ns/10ps
module dcil_cpu_model
(
  // clock and bus from the device
  input wire clk_in,
  input wire [7:0] data_out_in,
  input wire data_oe_in,
  // processor pins
  output reg ce_n_out,
  output reg rd_n_out,
  output reg wr_n_out,
  output reg vec_sel_out,
  output reg ack_n_out,
  // captured read result
  output reg got_valid_out,
  output reg [8:0] got_out
);
  initial
  begin
    {ce_n_out, rd_n_out, wr_n_out, ack_n_out} = 4'hF;
    {vec_sel_out, got_valid_out, got_out} = 11'h000;
  end
  task tick(input integer n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask
  // select is qualified, acknowledge has its own strobe
  task cycle(input ack, input vs, input integer waits);
    tick(1);
    ce_n_out = ack;
    ack_n_out = !ack;
    vec_sel_out = vs;
    tick(waits); // stretch before the read strobe, in any cycle kind
    rd_n_out = 1'b0;
    tick(5);
    got_out = {data_oe_in, data_oe_in ? data_out_in : 8'h00};
    got_valid_out = 1'b1;
    {ce_n_out, rd_n_out, ack_n_out} = 3'h7;
    tick(1);
    got_valid_out = 1'b0;
    tick(4);
  endtask
  task both_strobes;
    tick(1);
    {rd_n_out, wr_n_out} = 2'h0;
    tick(4);
    {rd_n_out, wr_n_out} = 2'h3;
    tick(3);
  endtask
endmodule

// File: bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  reg clk_in = 0, rst_in = 1, clri = 0, master_irq_enable = 1, vector_includes_status = 0, disable_lower_chain_cmd = 0, chn = 1;
  reg [3:0] ev = 0, clrp = 0, acc = 0;
  reg [7:0] base = 0, dbus = 0, lfsr_r = 8'h04;
  wire ce_n, rd_n, wr_n, vsel, ack_n, oe, irq_n, irq_oe, cho, gv;
  wire [7:0] dout, cvec;
  wire [3:0] pend, in_service_latch;
  wire [8:0] got;
  integer num_errors = 0, check_count = 0;
  reg [8:0] exp_q[$];
  always #12.5 clk_in = ~clk_in;
  function [7:0] lfsr(input [7:0] v);
    lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function [7:0] vx(input [2:0] i);
    vx = {base[7:4], i, base[0]};
  endfunction
  // bus input half sees a changing pattern, never a held value
  always @(posedge clk_in) #2 lfsr_r = lfsr(lfsr_r);
  always @* dbus = lfsr_r;
  dcil_core dut (.clk_in(clk_in), .rst_in(rst_in), .ce_n_in(ce_n),
    .rd_n_in(rd_n), .wr_n_in(wr_n), .vec_sel_in(vsel),
    .irq_acknowledge_n_in(ack_n), .chain_enable_in(chn), .data_in(dbus),
    .data_out(dout), .data_oe_out(oe), .irq_n_out(irq_n),
    .irq_oe_out(irq_oe), .chain_enable_out(cho), .irq_event_in(ev),
    .clear_pending_cmd_in(clrp), .data_access_in(acc),
    .clear_in_service_cmd_in(clri), .master_irq_enable_in(master_irq_enable),
    .vector_includes_status_in(vector_includes_status), .disable_lower_chain_cmd_in(disable_lower_chain_cmd),
    .base_vector_in(base), .pending_out(pend), .in_service_out(in_service_latch),
    .current_vector_out(cvec));
  dcil_cpu_model cpu (.clk_in(clk_in), .data_out_in(dout), .data_oe_in(oe),
    .ce_n_out(ce_n), .rd_n_out(rd_n), .wr_n_out(wr_n), .vec_sel_out(vsel),
    .ack_n_out(ack_n), .got_valid_out(gv), .got_out(got));
  task check(input [8:0] e, input [8:0] a);
    check_count = check_count + 1;
    if (a !== e)
    begin
      num_errors = num_errors + 1;
      $display("[ERR] %0t exp %h got %h", $time, e, a);
    end
  endtask
  always @(posedge clk_in) if (gv === 1'b1) check(exp_q.pop_front(), got);
  task results;
    if (exp_q.size() != 0)
    begin
      num_errors = num_errors + 1;
      $display("[ERR] %0t exp %h got %h", $time, 0, exp_q.size());
    end
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask
  initial
  begin
    #(25 * 3000);
    num_errors = num_errors + 1;
    results;
  end
  initial
  begin
    // status bits set so the raw and the status vector differ
    base = lfsr(lfsr(lfsr_r)) | 8'h8E;
    tick(8);
    rst_in = 0;
    tick(3);
    check(9'h0FF, 9'(cvec));
    ev = 4'h4;
    tick(1);
    ev = 0;
    tick(2);
    check(9'h004, 9'(pend));
    check(9'h001, 9'(irq_oe));
    exp_q.push_back({1'b1, vx(3'h2)});
    exp_q.push_back(9'h104);
    cpu.cycle(0, 1, 0);
    cpu.cycle(0, 0, 0);
    chn = 0;
    exp_q.push_back(9'h000);
    fork
      cpu.cycle(1, 1, 4);
      begin
        tick(3);
        ev = 4'h2;
        tick(1);
        ev = 0;
        tick(2);
        check(9'h004, 9'(pend));
      end
    join
    tick(2);
    check(9'h006, 9'(pend));
    check(9'h000, 9'(in_service_latch));
    chn = 1;
    vector_includes_status = 1;
    exp_q.push_back({1'b1, vx(3'h1)});
    cpu.cycle(1, 1, 2);
    check(9'h002, 9'(in_service_latch));
    check(9'h000, 9'({cho, irq_oe}));
    clrp = 4'h2;
    acc = 4'h4;
    tick(1);
    clrp = 0;
    acc = 0;
    tick(2);
    check(9'h000, 9'(pend));
    check(9'h0FF, 9'(cvec));
    check(9'h002, 9'(in_service_latch));
    clri = 1;
    tick(1);
    clri = 0;
    ev = 4'h8;
    tick(1);
    ev = 0;
    tick(3);
    check(9'h000, 9'(in_service_latch));
    check(9'h001, 9'(cho));
    disable_lower_chain_cmd = 1;
    tick(2);
    check(9'h000, 9'(cho));
    disable_lower_chain_cmd = 0;
    ev = 4'h1;
    vector_includes_status = 0;
    tick(1);
    ev = 0;
    exp_q.push_back({1'b1, vx(3'h0)});
    exp_q.push_back({1'b1, base});
    cpu.cycle(0, 1, 0);
    cpu.cycle(1, 1, 3);
    check(9'h001, 9'(in_service_latch));
    check(9'h009, 9'(pend));
    clri = 1;
    acc = 4'h1;
    tick(1);
    clri = 0;
    acc = 0;
    master_irq_enable = 0;
    tick(2);
    check(9'h000, 9'(irq_oe));
    exp_q.push_back(9'h000);
    cpu.cycle(1, 1, 0);
    check(9'h000, 9'(in_service_latch));
    master_irq_enable = 1;
    cpu.both_strobes;
    check(9'h000, 9'(pend));
    check(9'h0FF, 9'(cvec));
    results;
  end
endmodule
